//--- hdl/cllg_defines.vh
// Register indices, field positions, encodings and reset values of the look-up table glue block
`ifndef CLLG_DEFINES_VH
`define CLLG_DEFINES_VH

// Register indices, byte address is four times the index
`define CLLG_IDX_GLOBAL 4'h0
`define CLLG_IDX_SEQ 4'h1
`define CLLG_IDX_T0_CTRLA 4'h5
`define CLLG_IDX_T0_CTRLB 4'h6
`define CLLG_IDX_T0_CTRLC 4'h7
`define CLLG_IDX_T0_TRUTH 4'h8
`define CLLG_IDX_T1_CTRLA 4'h9
`define CLLG_IDX_T1_CTRLB 4'hA
`define CLLG_IDX_T1_CTRLC 4'hB
`define CLLG_IDX_T1_TRUTH 4'hC
`define CLLG_IDX_STATUS 4'hD
`define CLLG_TABLE_STRIDE 4'h4

// Global control fields
`define CLLG_GLOBAL_EN_BIT 0
`define CLLG_GLOBAL_STDBY_BIT 6

// Control A fields of each table
`define CLLG_CTA_EN_BIT 0
`define CLLG_CTA_OUTEN_BIT 3
`define CLLG_CTA_FILT_LO 4
`define CLLG_CTA_CLKSEL_BIT 6
`define CLLG_CTA_EDGE_BIT 7
`define CLLG_CTA_MASK 8'hF9

// Input source encodings
`define CLLG_SRC_MASK 4'h0
`define CLLG_SRC_FEEDBACK 4'h1
`define CLLG_SRC_LINK 4'h2
`define CLLG_SRC_EVENT_LINE_ZERO 4'h3
`define CLLG_SRC_EVENT_LINE_ONE 4'h4
`define CLLG_SRC_PIN 4'h5
`define CLLG_SRC_PERIPH_A 4'h6
`define CLLG_SRC_PERIPH_B 4'h7

// Filter option encodings
`define CLLG_FILT_OFF 2'h0
`define CLLG_FILT_SYNC 2'h1
`define CLLG_FILT_FILTER 2'h2

// Sequential mode encodings
`define CLLG_SEQ_OFF 4'h0
`define CLLG_SEQ_DFF 4'h1
`define CLLG_SEQ_JK 4'h2
`define CLLG_SEQ_DLATCH 4'h3
`define CLLG_SEQ_RS 4'h4

// Reset values
`define CLLG_RST_BYTE 8'h00

// AXI4-Lite responses
`define CLLG_RESP_OKAY 2'h0
`define CLLG_RESP_SLVERR 2'h2

`endif

//--- hdl/cllg_top.v
// Look-up table glue block with its AXI4-Lite register slave
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cllg_defines.vh"

module cllg_top #(
    parameter ADDR_W = 6
) (
    input wire core_clk,
    input wire reset_n,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [5:0] tableInputPins,
    input wire eventLineZero,
    input wire eventLineOne,
    input wire periphA,
    input wire periphB,
    output wire [1:0] tableOutputPin,
    output wire [1:0] tableOutputEvent,
    output wire pairSequentialOut
);

    // ************************************************************
    // Register storage
    // ************************************************************
    reg globEn_ff;
    reg runStdby_ff;
    reg [3:0] seqMode_ff;
    reg [15:0] ctrlA_ff;
    reg [15:0] ctrlB_ff;
    reg [15:0] ctrlC_ff;
    reg [15:0] truth_ff;
    reg seqOut_ff;

    // Bus handshake state
    reg awHeld_ff;
    reg wHeld_ff;
    reg [3:0] awIdx_ff;
    reg [7:0] wByte_ff;
    reg wLane_ff;

    // Per-table results shared between tables
    wire [1:0] tableRaw;
    wire [1:0] tableRes;
    wire [1:0] tableEn;
    wire [1:0] tableTick;

    // Input source multiplexer
    function srcPick;
        input [3:0] code;
        input pinV;
        input linkV;
        input fbV;
        input evA;
        input evB;
        input perA;
        input perB;
        begin
            case (code)
                `CLLG_SRC_FEEDBACK: srcPick = fbV;
                `CLLG_SRC_LINK: srcPick = linkV;
                `CLLG_SRC_EVENT_LINE_ZERO: srcPick = evA;
                `CLLG_SRC_EVENT_LINE_ONE: srcPick = evB;
                `CLLG_SRC_PIN: srcPick = pinV;
                `CLLG_SRC_PERIPH_A: srcPick = perA;
                `CLLG_SRC_PERIPH_B: srcPick = perB;
                default: srcPick = 1'b0;
            endcase
        end
    endfunction

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    wire wrFire;
    wire [3:0] wrIdx;
    wire wrMapped;
    wire wrTbl;
    wire [1:0] wrOff;
    wire [3:0] wrRel;
    wire [7:0] newA;
    wire [7:0] oldA;

    assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
    assign wrFire = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign wrIdx = awIdx_ff;
    assign wrTbl = (wrIdx >= `CLLG_IDX_T1_CTRLA);
    assign wrRel = wrTbl ? (wrIdx - `CLLG_IDX_T1_CTRLA) : (wrIdx - `CLLG_IDX_T0_CTRLA);
    assign wrOff = wrRel[1:0]; // Offset within one table's group
    assign wrMapped = (wrIdx <= `CLLG_IDX_SEQ) || ((wrIdx >= `CLLG_IDX_T0_CTRLA) && (wrIdx <= `CLLG_IDX_STATUS));
    assign oldA = wrTbl ? ctrlA_ff[15:8] : ctrlA_ff[7:0];
    // Protected fields follow the write only while the table is disabled
    assign newA = oldA[`CLLG_CTA_EN_BIT] ? {oldA[7:1], wByte_ff[0]} : (wByte_ff & `CLLG_CTA_MASK);

    // Address and data capture, either order
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awIdx_ff <= 4'h0;
            wByte_ff <= `CLLG_RST_BYTE;
            wLane_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CLLG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awIdx_ff <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wByte_ff <= s_axi_wdata[7:0];
                wLane_ff <= s_axi_wstrb[0];
            end
            if (wrFire) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? `CLLG_RESP_OKAY : `CLLG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register updates with enable protection
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            globEn_ff <= 1'b0;
            runStdby_ff <= 1'b0;
            seqMode_ff <= `CLLG_SEQ_OFF;
            ctrlA_ff <= {`CLLG_RST_BYTE, `CLLG_RST_BYTE};
            ctrlB_ff <= {`CLLG_RST_BYTE, `CLLG_RST_BYTE};
            ctrlC_ff <= {`CLLG_RST_BYTE, `CLLG_RST_BYTE};
            truth_ff <= {`CLLG_RST_BYTE, `CLLG_RST_BYTE};
        end else if (wrFire && wLane_ff) begin
            if (wrIdx == `CLLG_IDX_GLOBAL) begin
                globEn_ff <= wByte_ff[`CLLG_GLOBAL_EN_BIT];
                runStdby_ff <= wByte_ff[`CLLG_GLOBAL_STDBY_BIT];
            end
            if ((wrIdx == `CLLG_IDX_SEQ) && !ctrlA_ff[`CLLG_CTA_EN_BIT]) begin
                seqMode_ff <= wByte_ff[3:0];
            end
            if ((wrIdx >= `CLLG_IDX_T0_CTRLA) && (wrIdx <= `CLLG_IDX_T1_TRUTH)) begin
                case (wrOff)
                    2'h0: begin
                        if (wrTbl) ctrlA_ff[15:8] <= newA;
                        else ctrlA_ff[7:0] <= newA;
                    end
                    2'h1: begin
                        if (!oldA[`CLLG_CTA_EN_BIT]) begin
                            if (wrTbl) ctrlB_ff[15:8] <= wByte_ff;
                            else ctrlB_ff[7:0] <= wByte_ff;
                        end
                    end
                    2'h2: begin
                        if (!oldA[`CLLG_CTA_EN_BIT]) begin
                            if (wrTbl) ctrlC_ff[15:8] <= {4'h0, wByte_ff[3:0]};
                            else ctrlC_ff[7:0] <= {4'h0, wByte_ff[3:0]};
                        end
                    end
                    default: begin
                        if (wrTbl) truth_ff[15:8] <= wByte_ff;
                        else truth_ff[7:0] <= wByte_ff;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    reg [7:0] rdByte;
    reg rdOk;
    wire [3:0] rdIdx;

    assign s_axi_arready = !s_axi_rvalid;
    assign rdIdx = s_axi_araddr[5:2];

    // Read data selection
    always @* begin
        rdByte = `CLLG_RST_BYTE;
        rdOk = 1'b1;
        case (rdIdx)
            `CLLG_IDX_GLOBAL: rdByte = {1'b0, runStdby_ff, 5'h00, globEn_ff};
            `CLLG_IDX_SEQ: rdByte = {4'h0, seqMode_ff};
            `CLLG_IDX_T0_CTRLA: rdByte = ctrlA_ff[7:0];
            `CLLG_IDX_T0_CTRLB: rdByte = ctrlB_ff[7:0];
            `CLLG_IDX_T0_CTRLC: rdByte = ctrlC_ff[7:0];
            `CLLG_IDX_T0_TRUTH: rdByte = truth_ff[7:0];
            `CLLG_IDX_T1_CTRLA: rdByte = ctrlA_ff[15:8];
            `CLLG_IDX_T1_CTRLB: rdByte = ctrlB_ff[15:8];
            `CLLG_IDX_T1_CTRLC: rdByte = ctrlC_ff[15:8];
            `CLLG_IDX_T1_TRUTH: rdByte = truth_ff[15:8];
            `CLLG_IDX_STATUS: rdByte = {3'h0, seqOut_ff, tableEn, tableRes};
            default: rdOk = 1'b0;
        endcase
    end

    // Read answer one cycle after the address
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CLLG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rdByte};
            s_axi_rresp <= rdOk ? `CLLG_RESP_OKAY : `CLLG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Look-up tables and filters
    // ************************************************************
    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1) begin : gTable
            wire [7:0] cA;
            wire [7:0] cB;
            wire [3:0] cC;
            wire en;
            wire clkSel;
            wire [1:0] filter_option_select;
            wire linkV;
            wire in0;
            wire in1;
            wire in2Src;
            wire in2;
            reg in2Prev_ff;
            reg [3:0] filt_ff;
            reg filtOut_ff;
            reg res;

            assign cA = ctrlA_ff[t*8+7:t*8];
            assign cB = ctrlB_ff[t*8+7:t*8];
            assign cC = ctrlC_ff[t*8+3:t*8];
            assign en = globEn_ff && cA[`CLLG_CTA_EN_BIT];
            assign clkSel = cA[`CLLG_CTA_CLKSEL_BIT];
            assign filter_option_select = cA[`CLLG_CTA_FILT_LO+1:`CLLG_CTA_FILT_LO];
            // Highest table has no higher neighbour
            assign linkV = (t == 0) ? tableRaw[1] : 1'b0;

            // Input sources
            assign in0 = srcPick(cB[3:0], tableInputPins[t*3], linkV, seqOut_ff, eventLineZero, eventLineOne,
                periphA, periphB);
            assign in1 = srcPick(cB[7:4], tableInputPins[t*3+1], linkV, seqOut_ff, eventLineZero, eventLineOne,
                periphA, periphB);
            assign in2Src = srcPick(cC, tableInputPins[t*3+2], linkV, seqOut_ff, eventLineZero, eventLineOne,
                periphA, periphB);
            assign in2 = clkSel ? 1'b0 : in2Src;

            // Truth lookup, input two most significant
            assign tableRaw[t] = en & truth_ff[t*8 + {in2, in1, in0}];

            // Clock tick, peripheral clock or rising edge of input two
            assign tableTick[t] = clkSel ? (in2Src && !in2Prev_ff) : 1'b1;

            // Filter pipeline, cleared while the table is off
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    in2Prev_ff <= 1'b0;
                    filt_ff <= 4'h0;
                    filtOut_ff <= 1'b0;
                end else begin
                    in2Prev_ff <= in2Src;
                    if (!en) begin
                        filt_ff <= 4'h0;
                        filtOut_ff <= 1'b0;
                    end else if (tableTick[t]) begin
                        filt_ff <= {filt_ff[2:0], tableRaw[t]};
                        // Output moves only when three samples agree
                        if ((filt_ff[1] == filt_ff[2]) && (filt_ff[2] == filt_ff[3])) begin
                            filtOut_ff <= filt_ff[2];
                        end
                    end
                end
            end

            // Filter option selection
            always @* begin
                case (filter_option_select)
                    `CLLG_FILT_OFF: res = tableRaw[t];
                    `CLLG_FILT_SYNC: res = filt_ff[1];
                    default: res = filtOut_ff;
                endcase
            end

            assign tableRes[t] = res & en;
            assign tableEn[t] = en;
            assign tableOutputPin[t] = tableRes[t] & cA[`CLLG_CTA_OUTEN_BIT];
            assign tableOutputEvent[t] = tableRes[t];
        end
    endgenerate

    // ************************************************************
    // Pair sequential element
    // ************************************************************
    // Even table drives D, J or S; odd table drives G, K or R
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seqOut_ff <= 1'b0;
        end else if (!tableEn[0]) begin
            seqOut_ff <= 1'b0;
        end else begin
            case (seqMode_ff)
                `CLLG_SEQ_DFF: begin
                    if (tableTick[0] && tableRes[1]) seqOut_ff <= tableRes[0];
                end
                `CLLG_SEQ_JK: begin
                    if (tableTick[0]) begin
                        case ({tableRes[0], tableRes[1]})
                            2'b01: seqOut_ff <= 1'b0;
                            2'b10: seqOut_ff <= 1'b1;
                            2'b11: seqOut_ff <= !seqOut_ff;
                            default: seqOut_ff <= seqOut_ff;
                        endcase
                    end
                end
                `CLLG_SEQ_DLATCH: begin
                    if (tableRes[1]) seqOut_ff <= tableRes[0];
                end
                `CLLG_SEQ_RS: begin
                    // Both high is forbidden; hold
                    if (tableRes[0] && !tableRes[1]) seqOut_ff <= 1'b1;
                    else if (!tableRes[0] && tableRes[1]) seqOut_ff <= 1'b0;
                end
                default: seqOut_ff <= 1'b0;
            endcase
        end
    end

    // No halt input: logic runs through a processor debug halt
    assign pairSequentialOut = seqOut_ff;

endmodule

//--- verification/cllg_chk.sv
// Checker of bus answers and output gating of the glue block
`timescale 1ns/1ps
`include "cllg_defines.vh"
module cllg_chk #(
    parameter ADDR_W = 6
) (
    input wire core_clk,
    input wire reset_n,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire [1:0] tableOutputPin,
    input wire [1:0] tableOutputEvent
);
    // ****************
    // Enable shadow
    // ****************
    logic [3:0] awIdx_ff;
    logic [7:0] wByte_ff;
    logic wLane_ff, bvPrev_ff, glbEn_ff, hit, nxt_glbEn;
    logic [1:0] tblEn_ff, nxt_tblEn, effOn;
    // Shadow takes the stored byte on the edge the response rises
    assign hit = s_axi_bvalid && !bvPrev_ff && wLane_ff;
    assign nxt_glbEn = (hit && awIdx_ff == `CLLG_IDX_GLOBAL) ? wByte_ff[0] : glbEn_ff;
    assign nxt_tblEn[0] = (hit && awIdx_ff == `CLLG_IDX_T0_CTRLA) ? wByte_ff[0] : tblEn_ff[0];
    assign nxt_tblEn[1] = (hit && awIdx_ff == `CLLG_IDX_T1_CTRLA) ? wByte_ff[0] : tblEn_ff[1];
    assign effOn = {2{nxt_glbEn}} & nxt_tblEn;
    // Capture of write halves
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            awIdx_ff <= 4'h0;
            wByte_ff <= 8'h00;
            wLane_ff <= 1'b0;
            bvPrev_ff <= 1'b0;
            glbEn_ff <= 1'b0;
            tblEn_ff <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awIdx_ff <= s_axi_awaddr[5:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wByte_ff <= s_axi_wdata[7:0];
                wLane_ff <= s_axi_wstrb[0];
            end
            bvPrev_ff <= s_axi_bvalid;
            glbEn_ff <= nxt_glbEn;
            tblEn_ff <= nxt_tblEn;
        end
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
        else $error("read answer missing");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[5:2] inside {[2:4], 14, 15})
        |=> s_axi_rresp == `CLLG_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_unmapped_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && (s_axi_awaddr[5:2] inside {[2:4], 14, 15}) |-> ##2 s_axi_bresp == `CLLG_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_global_off: assert property ((!nxt_glbEn) [*2] |-> tableOutputPin == 2'h0 && tableOutputEvent == 2'h0)
        else $error("output high while block off");
    a_table0_off: assert property ((!effOn[0]) [*2] |-> !tableOutputPin[0] && !tableOutputEvent[0])
        else $error("table zero high while off");
    a_table1_off: assert property ((!effOn[1]) [*2] |-> !tableOutputPin[1] && !tableOutputEvent[1])
        else $error("table one high while off");
endmodule

//--- verification/cllg_partner.sv
// Model of the pins, event lines and peripheral sources
`timescale 1ns/1ps
module cllg_partner (
    input wire core_clk,
    input wire [5:0] pinCmd,
    input wire [3:0] lineCmd,
    output logic [5:0] tableInputPins,
    output logic eventLineZero,
    output logic eventLineOne,
    output logic periphA,
    output logic periphB
);
    // Known levels from time zero, routing settled first
    initial begin
        tableInputPins = 6'h00;
        {periphB, periphA, eventLineOne, eventLineZero} = 4'h0;
    end
    // Sources follow the bench one cycle later
    always @(posedge core_clk) begin
        tableInputPins <= pinCmd;
        {periphB, periphA, eventLineOne, eventLineZero} <= lineCmd;
    end
endmodule

//--- verification/cllg_tb_top.sv
// Self-checking bench of the glue block
`timescale 1ns/1ps
`include "cllg_defines.vh"
module cllg_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00, pinCmd = 6'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0, lineCmd = 4'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pairSequentialOut;
    wire [1:0] s_axi_bresp, s_axi_rresp, tableOutputPin, tableOutputEvent;
    wire [31:0] s_axi_rdata;
    wire [5:0] tableInputPins;
    wire eventLineZero, eventLineOne, periphA, periphB;
    int num_errors = 0, checked = 0, cycles = 0;
    cllg_top i_cllg_top (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .tableInputPins(tableInputPins), .eventLineZero(eventLineZero),
        .eventLineOne(eventLineOne), .periphA(periphA), .periphB(periphB), .tableOutputPin(tableOutputPin),
        .tableOutputEvent(tableOutputEvent), .pairSequentialOut(pairSequentialOut));
    cllg_partner i_cllg_partner (.core_clk(core_clk), .pinCmd(pinCmd), .lineCmd(lineCmd),
        .tableInputPins(tableInputPins), .eventLineZero(eventLineZero), .eventLineOne(eventLineOne),
        .periphA(periphA), .periphB(periphB));
    // ****************
    // Clock, watchdog, tasks
    // ****************
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic results;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er = `CLLG_RESP_OKAY);
        int n;
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input logic [1:0] er = `CLLG_RESP_OKAY);
        int n;
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        chk(s_axi_rdata, exp);
        chk({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
        s_axi_rready <= 1'b0;
    endtask
    // Disable, load fields and truth, then write control A
    task automatic cfg(input logic t, input logic [7:0] a, b, c, tr);
        logic [3:0] base;
        base = `CLLG_IDX_T0_CTRLA + (t ? `CLLG_TABLE_STRIDE : 4'h0);
        wr(base, 8'h00);
        wr(base + 4'h1, b);
        wr(base + 4'h2, c);
        wr(base + 4'h3, tr);
        wr(base, a);
    endtask
    task automatic settle;
        repeat (6) @(posedge core_clk);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [7:0] tr0, tr1;
        logic [3:0] sel;
        int i, n;
        n = $urandom(39796);
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        // Reset values, unmapped places refused
        for (i = 0; i < 16; i++) begin
            rd(i[3:0], 32'h00000000, (i inside {[2:4], 14, 15}) ? `CLLG_RESP_SLVERR : `CLLG_RESP_OKAY);
        end
        wr(4'hE, 8'hFF, `CLLG_RESP_SLVERR);
        // Lookup over all input codes, pins on every input
        tr0 = 8'($urandom);
        tr1 = 8'($urandom);
        cfg(1'b0, 8'h09, 8'h55, 8'h05, tr0);
        cfg(1'b1, 8'h09, 8'h55, 8'h05, tr1);
        wr(`CLLG_IDX_GLOBAL, 8'h01);
        for (i = 0; i < 8; i++) begin
            pinCmd <= {i[2:0], i[2:0]};
            settle();
            chk(tableOutputPin, {tr1[i], tr0[i]});
            chk(tableOutputEvent, {tr1[i], tr0[i]});
        end
        cfg(1'b0, 8'h09, 8'h05, 8'h05, tr0);
        pinCmd <= 6'h3F;
        settle();
        chk(tableOutputPin[0], tr0[5]);
        // Protected fields while enabled
        wr(`CLLG_IDX_T0_CTRLB, 8'h00);
        rd(`CLLG_IDX_T0_CTRLB, 32'h05);
        wr(`CLLG_IDX_T0_CTRLA, 8'h39);
        rd(`CLLG_IDX_T0_CTRLA, 32'h09);
        wr(`CLLG_IDX_T0_CTRLA, 8'h38);
        rd(`CLLG_IDX_T0_CTRLA, 32'h08);
        wr(`CLLG_IDX_T0_CTRLA, 8'h2F);
        rd(`CLLG_IDX_T0_CTRLA, 32'h29);
        // Filter delay for the synchroniser and filter options
        wr(`CLLG_IDX_T0_TRUTH, 8'h0F);
        for (i = 1; i < 3; i++) begin
            wr(`CLLG_IDX_T0_CTRLA, 8'h08);
            wr(`CLLG_IDX_T0_CTRLA, {2'h0, i[1:0], 4'h9});
            pinCmd <= 6'h00;
            settle();
            pinCmd <= 6'h3F;
            while (tableInputPins[2] !== 1'b1) @(posedge core_clk);
            n = 0;
            while (tableOutputPin[0] !== 1'b0 && n < 9) begin
                @(posedge core_clk);
                n++;
            end
            chk(n >= 2 && n <= 5, 1'b1);
        end
        // Sequential modes following the even table
        wr(`CLLG_IDX_SEQ, 8'h01);
        rd(`CLLG_IDX_SEQ, 32'h00);
        cfg(1'b0, 8'h00, 8'h00, 8'h05, 8'hF0);
        cfg(1'b1, 8'h09, 8'h00, 8'h05, 8'hFF);
        for (i = 1; i < 5; i++) begin
            wr(`CLLG_IDX_T0_CTRLA, 8'h00);
            wr(`CLLG_IDX_SEQ, i[7:0]);
            wr(`CLLG_IDX_T1_TRUTH, i[0] ? 8'hFF : 8'h0F);
            rd(`CLLG_IDX_SEQ, i);
            wr(`CLLG_IDX_T0_CTRLA, 8'h09);
            pinCmd <= 6'h24;
            settle();
            rd(`CLLG_IDX_STATUS, i[0] ? 32'h1F : 32'h1D);
            pinCmd <= 6'h00;
            settle();
            chk(pairSequentialOut, 1'b0);
        end
        // Latch output fed back into the odd table
        cfg(1'b1, 8'h09, 8'h01, 8'h00, 8'hAA);
        pinCmd <= 6'h24;
        settle();
        chk(tableOutputPin[1], 1'b1);
        // Events, peripherals and the linked table
        cfg(1'b0, 8'h09, 8'h02, 8'h00, 8'hAA);
        for (i = 0; i < 8; i++) begin
            sel = (i < 4) ? 4'(3 + i / 2) : 4'(4 + i / 2);
            lineCmd <= i[0] ? 4'(1 << (i / 2)) : ~4'(1 << (i / 2));
            cfg(1'b1, 8'h09, {4'h0, sel}, 8'h00, 8'hAA);
            settle();
            chk(tableOutputPin, {2{i[0]}});
        end
        wr(`CLLG_IDX_GLOBAL, 8'h00);
        settle();
        chk(tableOutputPin, 2'h0);
        wr(`CLLG_IDX_GLOBAL, 8'h01);
        wr(`CLLG_IDX_T1_CTRLA, 8'h00);
        settle();
        chk(tableOutputPin[1], 1'b0);
        // Input two as clock reads low in the lookup
        wr(`CLLG_IDX_GLOBAL, 8'h00);
        cfg(1'b0, 8'h49, 8'h00, 8'h05, 8'hF0);
        wr(`CLLG_IDX_GLOBAL, 8'h01);
        pinCmd <= 6'h04;
        settle();
        chk(tableOutputPin[0], 1'b0);
        results();
    end
endmodule
bind cllg_top cllg_chk #(.ADDR_W(ADDR_W)) i_cllg_chk (.core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .tableOutputPin(tableOutputPin), .tableOutputEvent(tableOutputEvent));
